/* File: rimb_pkg.sv */
// Purpose: shared constants for the receive interrupt mask bank
// Assumes: register indices are word indices; byte address is index * 4
// Notes: one slot per stored mask register of a port
package rimb_pkg;
  localparam int RIMB_NUM_PORTS = 16;
  localparam int RIMB_PORTS_PER_GROUP = 8;
  localparam int RIMB_GROUPS = 7;
  localparam int RIMB_SLOTS = 7;
  // per-port address stride and group jump, in register indices
  localparam logic [15:0] RIMB_PORT_STRIDE = 16'h0200;
  localparam logic [15:0] RIMB_GROUP_STRIDE = 16'h2000;
  // register indices inside one port space
  localparam logic [8:0] RIMB_IDX_ALARM = 9'h0A0;
  localparam logic [8:0] RIMB_IDX_E1_FRAMING = 9'h0A1;
  localparam logic [8:0] RIMB_IDX_CODE_CLOCK = 9'h0A2;
  localparam logic [8:0] RIMB_IDX_BUFFER_TIMER = 9'h0A3;
  localparam logic [8:0] RIMB_IDX_HDLC = 9'h0A4;
  localparam logic [8:0] RIMB_IDX_BOC_FDL = 9'h0A6;
  // block-wide registers, placed in the first port space
  localparam logic [8:0] RIMB_IDX_IRQ_STATUS = 9'h010;
  localparam logic [8:0] RIMB_IDX_IRQ_MASK = 9'h011;
  localparam logic [8:0] RIMB_IDX_LINE_MODE = 9'h012;
  // storage slots
  localparam int RIMB_SLOT_ALARM = 0;
  localparam int RIMB_SLOT_E1_FRAMING = 1;
  localparam int RIMB_SLOT_T1_CODE_CLOCK = 2;
  localparam int RIMB_SLOT_BUFFER_TIMER = 3;
  localparam int RIMB_SLOT_HDLC = 4;
  localparam int RIMB_SLOT_E1_LINK_CLOCK = 5;
  localparam int RIMB_SLOT_BOC_FDL = 6;
  // latched status groups feeding the summary
  localparam int RIMB_GRP_ALARM = 0;
  localparam int RIMB_GRP_TWO = 1;
  localparam int RIMB_GRP_CODE_CLOCK = 2;
  localparam int RIMB_GRP_BUFFER_TIMER = 3;
  localparam int RIMB_GRP_HDLC = 4;
  localparam int RIMB_GRP_RESERVED = 5;
  localparam int RIMB_GRP_BOC_FDL = 6;
  // alarm mask field positions
  localparam int RIMB_BIT_REMOTE_ALARM_CLEAR = 7;
  localparam int RIMB_BIT_AIS_CLEAR = 6;
  localparam int RIMB_BIT_SIGNAL_LOSS_CLEAR = 5;
  localparam int RIMB_BIT_FRAME_LOSS_CLEAR = 4;
  localparam int RIMB_BIT_REMOTE_ALARM_DETECT = 3;
  localparam int RIMB_BIT_AIS_DETECT = 2;
  localparam int RIMB_BIT_SIGNAL_LOSS_DETECT = 1;
  localparam int RIMB_BIT_FRAME_LOSS_DETECT = 0;
  // implemented bits of each slot; others read zero, except that E1 BOC/FDL bits 5-2 read back as written
  localparam logic [7:0] RIMB_VALID_ALARM = 8'hFF;
  localparam logic [7:0] RIMB_VALID_E1_FRAMING = 8'h0F;
  localparam logic [7:0] RIMB_VALID_T1_CODE_CLOCK = 8'hFF;
  localparam logic [7:0] RIMB_VALID_E1_LINK_CLOCK = 8'hBB;
  localparam logic [7:0] RIMB_VALID_BUFFER_TIMER = 8'hEF;
  localparam logic [7:0] RIMB_VALID_HDLC = 8'h3F;
  localparam logic [7:0] RIMB_VALID_T1_BOC_FDL = 8'h3F;
  localparam logic [7:0] RIMB_VALID_E1_BOC_FDL = 8'h03;
  localparam logic [7:0] RIMB_MASK_RESET = 8'h00;
  localparam logic [1:0] RIMB_HTRANS_NONSEQ = 2'b10;
endpackage

/* File: rimb_mask_if.sv */
// Purpose: carries one port's mask slots and line mode to its gate
// Assumes: driven from the register file on the same clock
// Notes: e1_mode high selects the E1 bit layouts
`timescale 1ns/1ps
interface rimb_mask_if import rimb_pkg::*; ();
  logic [RIMB_SLOTS-1:0][7:0] mask;
  logic e1_mode;
  modport ctrl (output mask, output e1_mode);
  modport gate (input mask, input e1_mode);
endinterface

/* File: rimb_port_gate.sv */
// Purpose: gates one port's latched receive status with its masks
// Assumes: status comes from logic on the same clock, no synchroniser
// Notes: summary and request are registered, one cycle behind status
`timescale 1ns/1ps
module rimb_port_gate import rimb_pkg::*; (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  rimb_mask_if.gate mif,
  input wire logic [RIMB_GROUPS-1:0][7:0] status_in,
  output logic [7:0] summary_out,
  output logic irq_out
);
  logic [RIMB_GROUPS-1:0][7:0] eff_mask;
  logic [7:0] summary_d;

  always_comb
  begin
    eff_mask = '0;
    // [R01] zero blocks, one enables
    eff_mask[RIMB_GRP_ALARM] = mif.mask[RIMB_SLOT_ALARM];
    // [R05] group two never requests in t1
    if (mif.e1_mode)
    begin
      eff_mask[RIMB_GRP_TWO] = mif.mask[RIMB_SLOT_E1_FRAMING] & RIMB_VALID_E1_FRAMING;
    end
    // [R09] layout follows line mode
    if (mif.e1_mode)
    begin
      // [R08] e1 link clock bits
      eff_mask[RIMB_GRP_CODE_CLOCK] =
        mif.mask[RIMB_SLOT_E1_LINK_CLOCK] & RIMB_VALID_E1_LINK_CLOCK;
      eff_mask[RIMB_GRP_BOC_FDL] = mif.mask[RIMB_SLOT_BOC_FDL] & RIMB_VALID_E1_BOC_FDL;
    end
    else
    begin
      // [R07] t1 code and clock bits
      eff_mask[RIMB_GRP_CODE_CLOCK] = mif.mask[RIMB_SLOT_T1_CODE_CLOCK];
      // [R12] t1 boc and fdl bits
      eff_mask[RIMB_GRP_BOC_FDL] = mif.mask[RIMB_SLOT_BOC_FDL] & RIMB_VALID_T1_BOC_FDL;
    end
    // [R10] buffer and timer bits
    eff_mask[RIMB_GRP_BUFFER_TIMER] =
      mif.mask[RIMB_SLOT_BUFFER_TIMER] & RIMB_VALID_BUFFER_TIMER;
    // [R11] hdlc fifo bits
    eff_mask[RIMB_GRP_HDLC] = mif.mask[RIMB_SLOT_HDLC] & RIMB_VALID_HDLC;
    // reserved group stays silent
    eff_mask[RIMB_GRP_RESERVED] = 8'h00;
  end

  always_comb
  begin
    summary_d = 8'h00;
    // [R14] masked bits left out of summary
    for (int g = 0; g < RIMB_GROUPS; g++)
    begin
      summary_d[g] = |(status_in[g] & eff_mask[g]);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      summary_out <= 8'h00;
      irq_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      summary_out <= summary_d;
      // [R15] any unmasked pair raises request
      irq_out <= |summary_d;
    end
  end
endmodule

/* File: rimb_top.sv */
// Purpose: receive interrupt mask bank for sixteen framer ports
// Assumes: AHB-Lite single word transfers, latched status on core clock
// Notes: reads take one wait state, writes none
//
// Behaviour
// [R01] A mask bit at zero blocks its receive event and at one lets it interrupt.
// [R02] Each mask register exists per port at base + 200h*(p-1) + 2000h*((p-1)/8).
// [R03] Alarm mask bits 6, 5, 4 enable the AIS, signal-loss and frame-loss clear events.
// [R04] Alarm mask bits 3 to 0 enable remote alarm, AIS, signal loss and frame loss detect.
// [R05] Latched group two never interrupts in T1, so its summary bit stays zero there.
// [R06] The E1 framing mask at 0A1h gates four signaling and alignment events in bits 3-0.
// [R07] In T1 the 0A2h mask gates clock loss, spare, loop-down, loop-up clear and detect.
// [R08] In E1 the 0A2h mask gates clock loss, V5.2 link and distant MF alarm, bits 6, 2 unused.
// [R09] The 0A2h address shows the T1 or E1 layout by the port's line mode.
// [R10] The 0A3h mask gates elastic store, signaling change, timer and multiframe events.
// [R11] The 0A4h mask gates six HDLC receive FIFO and packet events in bits 5 to 0.
// [R12] In T1 the 0A6h mask gates RAI-CI, AIS-CI, SLC-96, FDL full and BOC clear and detect.
// [R13] Alarm mask bit 7 enables the remote alarm clear event.
// [R14] A masked status bit is also left out of the per-port interrupt summary.
// [R15] A port requests while any latched status bit and its mask bit are both one.
`timescale 1ns/1ps
module rimb_top import rimb_pkg::*; #(
  parameter int NUM_PORTS = RIMB_NUM_PORTS
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic [NUM_PORTS-1:0][RIMB_GROUPS-1:0][7:0] rx_latched_status_in,
  output logic [NUM_PORTS-1:0][7:0] rx_interrupt_summary_out,
  output logic [NUM_PORTS-1:0] port_irq_out,
  output logic irq_out
);
  typedef struct packed {
    logic hit;
    logic glob;
    logic [3:0] port;
    logic [8:0] off;
  } rimb_dec_type;

  logic [NUM_PORTS-1:0][RIMB_SLOTS-1:0][7:0] mask_q;
  logic [NUM_PORTS-1:0] e1_mode_q;
  logic [NUM_PORTS-1:0] irq_status_q;
  logic [NUM_PORTS-1:0] irq_mask_q;
  logic [NUM_PORTS-1:0] port_irq_prev_q;
  logic [NUM_PORTS-1:0] port_irq;
  logic [15:0] idx_q;
  logic wr_pend_q;
  logic rd_wait_q;
  logic [31:0] hrdata_q;
  logic accept;
  rimb_dec_type dec;
  logic [31:0] rd_word;
  logic [2:0] slot;
  logic slot_ok;

  // [R02] port from index: 200h step, 2000h jump
  function automatic rimb_dec_type decode(input logic [15:0] idx);
    rimb_dec_type d;
    d.off = idx[8:0];
    d.port = {idx[13], idx[11:9]};
    d.glob = (idx[15:9] == 7'd0) &&
      (d.off == RIMB_IDX_IRQ_STATUS || d.off == RIMB_IDX_IRQ_MASK ||
       d.off == RIMB_IDX_LINE_MODE);
    // ports 9-16 carry both the 1000h step and the 2000h jump
    d.hit = (idx[15:14] == 2'd0) && (idx[12] == idx[13]) && (32'(d.port) < NUM_PORTS);
    return d;
  endfunction

  assign accept = hsel_in && hready_in && (htrans_in == RIMB_HTRANS_NONSEQ);
  assign dec = decode(idx_q);
  assign hreadyout_out = !rd_wait_q;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;

  // address to storage slot, 0A2h split by line mode
  always_comb
  begin
    slot = 3'd0;
    slot_ok = dec.hit;
    case (dec.off)
      RIMB_IDX_ALARM:
      begin
        slot = 3'(RIMB_SLOT_ALARM);
      end
      RIMB_IDX_E1_FRAMING:
      begin
        slot = 3'(RIMB_SLOT_E1_FRAMING);
      end
      RIMB_IDX_CODE_CLOCK:
      begin
        // [R09] one address, two layouts
        if (e1_mode_q[dec.port])
        begin
          slot = 3'(RIMB_SLOT_E1_LINK_CLOCK);
        end
        else
        begin
          slot = 3'(RIMB_SLOT_T1_CODE_CLOCK);
        end
      end
      RIMB_IDX_BUFFER_TIMER:
      begin
        slot = 3'(RIMB_SLOT_BUFFER_TIMER);
      end
      RIMB_IDX_HDLC:
      begin
        slot = 3'(RIMB_SLOT_HDLC);
      end
      RIMB_IDX_BOC_FDL:
      begin
        slot = 3'(RIMB_SLOT_BOC_FDL);
      end
      default:
      begin
        slot_ok = 1'b0;
      end
    endcase
  end

  // bits each slot keeps; unused bits read zero
  function automatic logic [7:0] valid_bits(input logic [2:0] s);
    logic [7:0] v;
    case (s)
      3'(RIMB_SLOT_ALARM): v = RIMB_VALID_ALARM;
      // [R06] e1 framing bits 3 to 0
      3'(RIMB_SLOT_E1_FRAMING): v = RIMB_VALID_E1_FRAMING;
      3'(RIMB_SLOT_T1_CODE_CLOCK): v = RIMB_VALID_T1_CODE_CLOCK;
      // [R08] bits 6 and 2 unused
      3'(RIMB_SLOT_E1_LINK_CLOCK): v = RIMB_VALID_E1_LINK_CLOCK;
      3'(RIMB_SLOT_BUFFER_TIMER): v = RIMB_VALID_BUFFER_TIMER;
      3'(RIMB_SLOT_HDLC): v = RIMB_VALID_HDLC;
      3'(RIMB_SLOT_BOC_FDL): v = RIMB_VALID_T1_BOC_FDL;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // read mux, unmapped reads return zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (dec.glob)
    begin
      case (dec.off)
        RIMB_IDX_IRQ_STATUS: rd_word[NUM_PORTS-1:0] = irq_status_q;
        RIMB_IDX_IRQ_MASK: rd_word[NUM_PORTS-1:0] = irq_mask_q;
        RIMB_IDX_LINE_MODE: rd_word[NUM_PORTS-1:0] = e1_mode_q;
        default: rd_word = 32'h0000_0000;
      endcase
    end
    else if (slot_ok)
    begin
      rd_word[7:0] = mask_q[dec.port][slot];
    end
  end

  // bus address phase capture
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      idx_q <= 16'h0000;
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (accept)
      begin
        // high address bits park on an unmapped index, so reads give zero
        idx_q <= (haddr_in[31:18] == 14'd0) ? haddr_in[17:2] : 16'hFFFF;
      end
      wr_pend_q <= accept && hwrite_in && (haddr_in[31:18] == 14'd0);
      rd_wait_q <= accept && !hwrite_in;
    end
  end

  // read data loaded in the wait state
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (clk_en_in && rd_wait_q)
    begin
      hrdata_q <= rd_word;
    end
  end

  // mask storage per port
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mask_q <= {NUM_PORTS * RIMB_SLOTS{RIMB_MASK_RESET}};
    end
    // [R02] replicated per port
    else if (clk_en_in && wr_pend_q && slot_ok && !dec.glob)
    begin
      // [R03] [R04] [R13] alarm mask bits kept as written
      mask_q[dec.port][slot] <= hwdata_in[7:0] & valid_bits(slot);
    end
  end

  // line mode, high selects e1 layouts
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      e1_mode_q <= '0;
      irq_mask_q <= '0;
    end
    else if (clk_en_in && wr_pend_q && dec.glob)
    begin
      if (dec.off == RIMB_IDX_LINE_MODE)
      begin
        e1_mode_q <= hwdata_in[NUM_PORTS-1:0];
      end
      if (dec.off == RIMB_IDX_IRQ_MASK)
      begin
        irq_mask_q <= hwdata_in[NUM_PORTS-1:0];
      end
    end
  end

  // sticky port request events, set beats write-one clear
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_status_q <= '0;
      port_irq_prev_q <= '0;
    end
    else if (clk_en_in)
    begin
      port_irq_prev_q <= port_irq;
      if (wr_pend_q && dec.glob && dec.off == RIMB_IDX_IRQ_STATUS)
      begin
        irq_status_q <= (irq_status_q & ~hwdata_in[NUM_PORTS-1:0]) |
          (port_irq & ~port_irq_prev_q);
      end
      else
      begin
        irq_status_q <= irq_status_q | (port_irq & ~port_irq_prev_q);
      end
    end
  end

  // combined line is a level
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      irq_out <= |(irq_status_q & irq_mask_q);
    end
  end

  assign port_irq_out = port_irq;

  // one gate per port; a stuck status bit whose mask bit is open keeps the port request high
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    rimb_mask_if mif ();
    assign mif.mask = mask_q[p];
    assign mif.e1_mode = e1_mode_q[p];
    // [R15] port request from gated status
    rimb_port_gate u_gate (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .clk_en_in(clk_en_in),
      .mif(mif.gate),
      .status_in(rx_latched_status_in[p]),
      .summary_out(rx_interrupt_summary_out[p]),
      .irq_out(port_irq[p])
    );
  end
endmodule

/* File: rimb_props.sv */
// Purpose: port-level checks of the receive interrupt mask bank
// Assumes: one clock, asynchronous active-low reset
// Notes: line mode is internal, so group two is judged by the bench
`timescale 1ns/1ps
module rimb_props import rimb_pkg::*; #(
  parameter int NUM_PORTS = RIMB_NUM_PORTS
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [NUM_PORTS-1:0][RIMB_GROUPS-1:0][7:0] rx_latched_status_in,
  input wire logic [NUM_PORTS-1:0][7:0] rx_interrupt_summary_out,
  input wire logic [NUM_PORTS-1:0] port_irq_out,
  input wire logic irq_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  logic take_w;
  logic seen_q;
  // a request only counts while the clock is enabled
  assign take_w = hsel_in && hready_in && htrans_in == RIMB_HTRANS_NONSEQ && clk_en_in;
  // sticky, so a cleared port request still explains a later interrupt
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      seen_q <= 1'b0;
    end
    else if (|port_irq_out)
    begin
      seen_q <= 1'b1;
    end
  end
  AST_READ_WAIT: assert property (
    take_w && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state is not one cycle");
  AST_WRITE_NOWAIT: assert property (take_w && hwrite_in |=> hreadyout_out)
    else $error("write was stalled");
  AST_OKAY: assert property (hresp_out == 1'b0)
    else $error("response not okay");
  AST_FREEZE: assert property (
    !clk_en_in |=> $stable(rx_interrupt_summary_out) && $stable(irq_out))
    else $error("outputs moved with clock enable low");
  AST_IRQ_CAUSE: assert property (irq_out |-> seen_q)
    else $error("interrupt without any port request");
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    AST_PORT_REQ: assert property (port_irq_out[p] == |rx_interrupt_summary_out[p])
      else $error("port request differs from summary");
    AST_RESERVED: assert property (
      !rx_interrupt_summary_out[p][7] && !rx_interrupt_summary_out[p][5])
      else $error("reserved summary bit set");
    for (genvar g = 0; g < RIMB_GROUPS; g++)
    begin : g_grp
      AST_SUMMARY_CAUSE: assert property (
        $past(clk_en_in) && rx_interrupt_summary_out[p][g] |-> $past(|rx_latched_status_in[p][g]))
        else $error("summary bit without latched status");
    end
  end
endmodule

/* File: rx_interrupt_mask_bank_tb_top.sv */
// Purpose: self-checking bench for the receive interrupt mask bank
// Assumes: one AHB-Lite master, hready looped back from the slave
// Notes: read data is judged by a monitor from a queue of expected words
`timescale 1ns/1ps
module rx_interrupt_mask_bank_tb_top import rimb_pkg::*;;
  localparam int NP = 16;
  logic clk, rst_n, clk_en, hsel, hwrite, rd_pend, hready, hresp, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [7:0] e;
  logic [NP-1:0][RIMB_GROUPS-1:0][7:0] status;
  logic [NP-1:0][7:0] summ;
  logic [NP-1:0] pirq;
  logic [31:0] rdq [$];
  int err_count, n_checks;
  logic [8:0] offs [6] = '{RIMB_IDX_ALARM, RIMB_IDX_E1_FRAMING, RIMB_IDX_CODE_CLOCK,
    RIMB_IDX_BUFFER_TIMER, RIMB_IDX_HDLC, RIMB_IDX_BOC_FDL};
  logic [7:0] vmask [6] = '{8'hFF, 8'h0F, 8'hFF, 8'hEF, 8'h3F, 8'h3F};
  int grp [6] = '{0, 1, 2, 3, 4, 6};
  // ports either side of the group jump
  int ports [4] = '{1, 8, 9, 16};
  rimb_top #(.NUM_PORTS(NP)) u_dut (
    .core_clk_in(clk), .arst_n_in(rst_n), .clk_en_in(clk_en), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
    .hready_in(hready), .hwdata_in(hwdata), .hreadyout_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .rx_latched_status_in(status), .rx_interrupt_summary_out(summ),
    .port_irq_out(pirq), .irq_out(irq));
  always #5 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait; a hung bus ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (hready !== 1'b1)
    begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= RIMB_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rd_pend <= !wr;
    wait_rdy();
    rd_pend <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [31:0] ra(input int p, input logic [8:0] off);
    logic [15:0] i;
    i = 16'(off) + RIMB_PORT_STRIDE * 16'(p - 1) + RIMB_GROUP_STRIDE * 16'((p - 1) / 8);
    return {14'h0000, i, 2'b00};
  endfunction
  // read data is taken at the edge that ends the data phase
  always @(posedge clk)
  begin
    if (rd_pend === 1'b1 && hready === 1'b1)
    begin
      check("read data", rdq.pop_front(), hrdata);
    end
  end
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = '0;
    hwrite = 1'b0;
    hwdata = '0;
    rd_pend = 1'b0;
    status = '0;
    err_count = 0;
    n_checks = 0;
    void'($urandom(84));
    tick(8);
    rst_n <= 1'b1;
    foreach (ports[k])
      foreach (offs[j])
      begin
        rd(ra(ports[k], offs[j]), 32'h0000_0000);
        d = $urandom;
        wr(ra(ports[k], offs[j]), d);
        e = d[7:0] & vmask[j];
        rd(ra(ports[k], offs[j]), 32'(e));
      end
    wr(ra(1, 9'h0A5), 32'h0000_00FF);
    rd(ra(1, 9'h0A5), 32'h0000_0000);
    // high address bits over a live mask stay unmapped
    wr(ra(1, RIMB_IDX_ALARM), 32'h0000_00FF);
    rd(32'h0004_0280, 32'h0000_0000);
    // one event at a time on port 3, closed then opened
    foreach (offs[j])
      for (int b = 0; b < 8; b++)
        if (vmask[j][b])
        begin
          tick(1);
          status[2][grp[j]] <= 8'(1 << b);
          tick(2);
          check("summary masked", 32'h0000_0000, 32'(summ[2]));
          wr(ra(3, offs[j]), 32'(1 << b));
          tick(2);
          e = (j == 1) ? 8'h00 : 8'(1 << grp[j]);
          check("summary open", 32'(e), 32'(summ[2]));
          check("port request", 32'(e != 0), 32'(pirq[2]));
          wr(ra(3, offs[j]), 32'h0000_0000);
          status[2][grp[j]] <= 8'h00;
        end
    wr(ra(9, RIMB_IDX_CODE_CLOCK), 32'h0000_005A);
    wr(ra(1, RIMB_IDX_LINE_MODE), 32'h0000_0100);
    wr(ra(9, RIMB_IDX_CODE_CLOCK), 32'h0000_00FF);
    rd(ra(9, RIMB_IDX_CODE_CLOCK), 32'h0000_00BB);
    wr(ra(9, RIMB_IDX_E1_FRAMING), 32'h0000_0004);
    status[8][1] <= 8'h04;
    status[8][2] <= 8'h44;
    // reserved group must stay silent
    status[8][5] <= 8'hFF;
    tick(2);
    check("e1 summary", 32'h0000_0002, 32'(summ[8]));
    clk_en <= 1'b0;
    status[8] <= '0;
    tick(3);
    check("frozen summary", 32'h0000_0002, 32'(summ[8]));
    clk_en <= 1'b1;
    tick(2);
    check("released summary", 32'h0000_0000, 32'(summ[8]));
    wr(ra(1, RIMB_IDX_LINE_MODE), 32'h0000_0000);
    rd(ra(9, RIMB_IDX_CODE_CLOCK), 32'h0000_005A);
    check("irq masked", 32'h0000_0000, 32'(irq));
    rd(ra(1, RIMB_IDX_IRQ_STATUS), 32'h0000_0104);
    wr(ra(1, RIMB_IDX_IRQ_MASK), 32'h0000_0004);
    tick(2);
    check("irq open", 32'h0000_0001, 32'(irq));
    wr(ra(1, RIMB_IDX_IRQ_STATUS), 32'h0000_0104);
    rd(ra(1, RIMB_IDX_IRQ_STATUS), 32'h0000_0000);
    check("irq cleared", 32'h0000_0000, 32'(irq));
    complete_run();
  end
endmodule
bind rimb_top rimb_props #(.NUM_PORTS(NUM_PORTS)) u_props (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
  .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .rx_latched_status_in(rx_latched_status_in),
  .rx_interrupt_summary_out(rx_interrupt_summary_out), .port_irq_out(port_irq_out),
  .irq_out(irq_out));
